// >>> hw/avadc_spi_slave.v
// SPI slave (mode 0) with pin synchronisers and register access strobes
`timescale 1ns/1ps
module avadc_spi_slave (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // SPI pins
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso_ff,
  output reg spi_miso_oe_ff,
  // Register access
  output reg [6:0] addr_ff,
  output reg wr_ff,
  output reg [15:0] wdata_ff,
  input wire [15:0] rdata
);

  // --------------------------------------------------------------------
  // Pin synchronisers: three stages, filtered when stages 2 and 3 agree
  // --------------------------------------------------------------------
  reg [2:0] sync1_ff; // First stage, read only by stage two
  reg [2:0] sync2_ff;
  reg [2:0] sync3_ff;
  reg [2:0] filt_ff; // {cs_n, sck, mosi} filtered
  wire [2:0] nxt_filt;

  assign nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));

  // Synchroniser chain and filter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 3'h4;
      sync2_ff <= 3'h4;
      sync3_ff <= 3'h4;
      filt_ff <= 3'h4;
    end else begin
      sync1_ff <= {spi_cs_n, spi_sck, spi_mosi};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= nxt_filt;
    end
  end

  wire cs_act = ~filt_ff[2];
  wire sck_rise = nxt_filt[1] & ~filt_ff[1];
  wire sck_fall = ~nxt_filt[1] & filt_ff[1];

  // --------------------------------------------------------------------
  // Frame: 8 command bits (write flag, 7-bit address), 16 data bits
  // --------------------------------------------------------------------
  reg [4:0] cnt_ff; // Bits received in this frame
  reg [15:0] rx_ff; // Receive shift register
  reg [15:0] tx_ff; // Transmit shift register
  reg load_ff; // Load read data on next cycle
  reg is_wr_ff; // Frame is a write

  // Shift engine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      load_ff <= 1'b0;
      is_wr_ff <= 1'b0;
      addr_ff <= 7'h00;
      wr_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      spi_miso_ff <= 1'b0;
      spi_miso_oe_ff <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      load_ff <= 1'b0;
      spi_miso_oe_ff <= cs_act;
      if (!cs_act) begin
        // Deselected: abandon any partial frame
        cnt_ff <= 5'h00;
        spi_miso_ff <= 1'b0;
      end else begin
        if (load_ff) begin
          tx_ff <= rdata;
        end
        if (sck_rise && cnt_ff != 5'h18) begin
          cnt_ff <= cnt_ff + 5'h01;
          rx_ff <= {rx_ff[14:0], filt_ff[0]};
          if (cnt_ff == 5'h07) begin
            // Command byte complete
            is_wr_ff <= rx_ff[6];
            addr_ff <= {rx_ff[5:0], filt_ff[0]};
            load_ff <= 1'b1;
          end
          if (cnt_ff == 5'h17 && is_wr_ff) begin
            // Data word complete: one-cycle write strobe
            wr_ff <= 1'b1;
            wdata_ff <= {rx_ff[14:0], filt_ff[0]};
          end
        end
        if (sck_fall && cnt_ff >= 5'h08 && cnt_ff < 5'h18) begin
          spi_miso_ff <= tx_ff[15];
          tx_ff <= {tx_ff[14:0], 1'b0};
        end
      end
    end
  end

endmodule // avadc_spi_slave

// >>> hw/avadc_top.v
// Aux voltage ADC control: target sequencing, done flag, latch, results
// Functional notes
// - Supply rail 5.5V converted in measurement cycle
// - Target bit 6 selects 5.5V rail
// - Target bit 13 selects external regulator
// - Target bit 12 selects 1.8V regulator
// - Pin1 function 0011 outputs done interrupt
// - Continuous bit repeats measurement cycles
// - One-shot trigger starts cycle, self-clears after
// - Interrupt goes high on measurement completion
// - Done flag set on measurement completion
// - Done flag cleared by writing one
// - Latch request copies codes to results
// - Latch end clears request, drops interrupt
// - Results readable at 0x44, 0x4A, 0x49
// - 5.5V result is 14-bit unsigned code
// - Regulator result same 14-bit code format
// - Thermistor results 14-bit unsigned codes
// - Pull-up only while its input converts
`timescale 1ns/1ps
`include "avadc_defines.vh"
module avadc_top (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // SPI pins
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  // General pin 1 output
  output reg pin1_out_ff,
  output reg pin1_oe_ff,
  // Analog converter core
  output reg adc_start_ff,
  output reg [2:0] adc_chan_ff,
  input wire adc_done,
  input wire [13:0] adc_code,
  // Thermistor pull-up switches
  output reg [4:0] pullup_en_ff
);

  // --------------------------------------------------------------------
  // State encoding
  // --------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0; // Waiting for a start
  localparam [1:0] ST_SCAN = 2'h1; // Looking for next selected target
  localparam [1:0] ST_CONV = 2'h2; // Conversion in progress
  localparam [1:0] ST_DONE = 2'h3; // Cycle complete

  // Latch reload value; only the low five bits feed the counter
  localparam [31:0] LATCH_LAST = `AVADC_LATCH_CYC - 1;

  // --------------------------------------------------------------------
  // Target select bit for a channel index
  // --------------------------------------------------------------------
  function ch_selected;
    input [15:0] tsel;
    input [2:0] ch;
    begin
      if (ch == `AVADC_CH_SUPPLY55) begin
        ch_selected = tsel[`AVADC_BIT_SUPPLY55];
      end else if (ch == `AVADC_CH_CORE18) begin
        ch_selected = tsel[`AVADC_BIT_CORE18];
      end else if (ch == `AVADC_CH_EXTREG) begin
        ch_selected = tsel[`AVADC_BIT_EXTREG];
      end else begin
        // Thermistor inputs 1 to 5 sit on bits 5:1
        ch_selected = tsel[`AVADC_BIT_THERM_LO + ch];
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Register access port
  // --------------------------------------------------------------------
  wire [6:0] bus_addr; // Address of current frame
  wire bus_wr; // One-cycle write strobe
  wire [15:0] bus_wdata; // Write data
  reg [15:0] bus_rdata; // Read data for current address

  avadc_spi_slave u_spi (
    .clk(clk),
    .rst_n(rst_n),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso_ff(spi_miso),
    .spi_miso_oe_ff(spi_miso_oe),
    .addr_ff(bus_addr),
    .wr_ff(bus_wr),
    .wdata_ff(bus_wdata),
    .rdata(bus_rdata)
  );

  // --------------------------------------------------------------------
  // Control and status state
  // --------------------------------------------------------------------
  reg [15:0] mode_ff; // Mode register, continuous bit
  reg [15:0] target_ff; // Target select register
  reg trig_ff; // One-shot trigger
  reg latch_req_ff; // Latch request in progress
  reg [15:0] pin1_ff; // Pin 1 configuration
  reg [4:0] pullup_sel_ff; // Pull-up enables per thermistor input
  reg done_ff; // Voltage conversion done flag
  reg irq_ff; // Conversion done interrupt level
  reg [1:0] state_ff; // Sequencer state
  reg [2:0] ch_ff; // Channel under scan
  reg [4:0] latch_cnt_ff; // Latch cycles remaining
  reg [13:0] conv_ff [0:7]; // Latest conversion codes
  reg [13:0] result_ff [0:7]; // Host visible latched codes

  wire wr_mode = bus_wr && bus_addr == `AVADC_ADDR_MODE;
  wire wr_target = bus_wr && bus_addr == `AVADC_ADDR_TARGET;
  wire wr_cmd = bus_wr && bus_addr == `AVADC_ADDR_CMD;
  wire wr_pin1 = bus_wr && bus_addr == `AVADC_ADDR_PIN1;
  wire wr_pullup = bus_wr && bus_addr == `AVADC_ADDR_PULLUP;
  wire wr_status = bus_wr && bus_addr == `AVADC_ADDR_STATUS;
  wire cycle_end = state_ff == ST_DONE;
  wire latch_start = wr_cmd && bus_wdata[`AVADC_BIT_LATCH] && !latch_req_ff;
  wire latch_end = latch_req_ff && latch_cnt_ff == 5'h00;
  // Thermistor result slot, offset from the first result address
  wire [6:0] therm_idx = bus_addr - `AVADC_ADDR_THERM_FIRST;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= 16'h0000;
      target_ff <= 16'h0000;
      pin1_ff <= `AVADC_RST_PIN1;
      pullup_sel_ff <= 5'h00;
    end else begin
      if (wr_mode) begin
        mode_ff <= bus_wdata;
      end
      if (wr_target) begin
        target_ff <= bus_wdata;
      end
      if (wr_pin1) begin
        pin1_ff <= bus_wdata;
      end
      if (wr_pullup) begin
        pullup_sel_ff <= bus_wdata[`AVADC_FLD_PULLUP_HI:`AVADC_FLD_PULLUP_LO];
      end
    end
  end

  // --------------------------------------------------------------------
  // Trigger, done flag and interrupt; hardware set beats clear
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      // Trigger self-clears at cycle end; a new write of one wins
      if (wr_cmd && bus_wdata[`AVADC_BIT_TRIG]) begin
        trig_ff <= 1'b1;
      end else if (cycle_end) begin
        trig_ff <= 1'b0;
      end
      if (cycle_end) begin
        done_ff <= 1'b1;
      end else if (wr_status && bus_wdata[`AVADC_BIT_DONE]) begin
        done_ff <= 1'b0;
      end
      if (cycle_end) begin
        irq_ff <= 1'b1;
      end else if (latch_end) begin
        irq_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Measurement sequencer: walks all selected targets once per cycle
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      ch_ff <= 3'h0;
      adc_start_ff <= 1'b0;
      adc_chan_ff <= 3'h0;
      pullup_en_ff <= 5'h00;
    end else begin
      adc_start_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (mode_ff[`AVADC_BIT_CONT] || trig_ff) begin
            state_ff <= ST_SCAN;
            ch_ff <= 3'h0;
          end
        end
        ST_SCAN: begin
          if (ch_selected(target_ff, ch_ff)) begin
            state_ff <= ST_CONV;
            adc_start_ff <= 1'b1;
            adc_chan_ff <= ch_ff;
            if (ch_ff < `AVADC_CH_SUPPLY55 && pullup_sel_ff[ch_ff]) begin
              pullup_en_ff[ch_ff] <= 1'b1;
            end
          end else if (ch_ff == 3'h7) begin
            state_ff <= ST_DONE;
          end else begin
            ch_ff <= ch_ff + 3'h1;
          end
        end
        ST_CONV: begin
          if (adc_done) begin
            pullup_en_ff <= 5'h00;
            if (ch_ff == 3'h7) begin
              state_ff <= ST_DONE;
            end else begin
              state_ff <= ST_SCAN;
              ch_ff <= ch_ff + 3'h1;
            end
          end
        end
        default: begin
          // Completion shows for one cycle, then continue or stop
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Conversion codes and host latch
  // --------------------------------------------------------------------
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `AVADC_NUM_CH; i = i + 1) begin
        conv_ff[i] <= 14'h0000;
        result_ff[i] <= 14'h0000;
      end
      latch_req_ff <= 1'b0;
      latch_cnt_ff <= 5'h00;
    end else begin
      if (state_ff == ST_CONV && adc_done) begin
        conv_ff[ch_ff] <= adc_code;
      end
      if (latch_start) begin
        for (i = 0; i < `AVADC_NUM_CH; i = i + 1) begin
          result_ff[i] <= conv_ff[i];
        end
        latch_req_ff <= 1'b1;
        latch_cnt_ff <= LATCH_LAST[4:0];
      end else if (latch_end) begin
        latch_req_ff <= 1'b0;
      end else if (latch_req_ff) begin
        latch_cnt_ff <= latch_cnt_ff - 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin 1: done interrupt when function selected and output enabled
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_out_ff <= 1'b0;
      pin1_oe_ff <= 1'b0;
    end else begin
      // Pin stays low unless the done function is chosen
      pin1_out_ff <= irq_ff &&
        pin1_ff[`AVADC_FLD_PIN1_SEL_HI:`AVADC_FLD_PIN1_SEL_LO] ==
        `AVADC_PIN1_SEL_IRQ;
      pin1_oe_ff <= !pin1_ff[`AVADC_BIT_PIN1_NOE];
    end
  end

  // --------------------------------------------------------------------
  // Read data decode; unmapped addresses read zero
  // --------------------------------------------------------------------
  always @* begin
    bus_rdata = 16'h0000;
    if (bus_addr == `AVADC_ADDR_MODE) begin
      bus_rdata = mode_ff;
    end else if (bus_addr == `AVADC_ADDR_TARGET) begin
      bus_rdata = target_ff;
    end else if (bus_addr == `AVADC_ADDR_CMD) begin
      bus_rdata[`AVADC_BIT_TRIG] = trig_ff;
      bus_rdata[`AVADC_BIT_LATCH] = latch_req_ff;
    end else if (bus_addr == `AVADC_ADDR_PIN1) begin
      bus_rdata = pin1_ff;
    end else if (bus_addr == `AVADC_ADDR_PULLUP) begin
      bus_rdata[`AVADC_FLD_PULLUP_HI:`AVADC_FLD_PULLUP_LO] = pullup_sel_ff;
    end else if (bus_addr == `AVADC_ADDR_STATUS) begin
      bus_rdata[`AVADC_BIT_DONE] = done_ff;
    end else if (bus_addr >= `AVADC_ADDR_THERM_FIRST &&
                 bus_addr <= `AVADC_ADDR_THERM_LAST) begin
      bus_rdata[13:0] = result_ff[therm_idx[2:0]];
    end else if (bus_addr == `AVADC_ADDR_SUPPLY55) begin
      bus_rdata[13:0] = result_ff[`AVADC_CH_SUPPLY55];
    end else if (bus_addr == `AVADC_ADDR_CORE18) begin
      bus_rdata[13:0] = result_ff[`AVADC_CH_CORE18];
    end else if (bus_addr == `AVADC_ADDR_EXTREG) begin
      bus_rdata[13:0] = result_ff[`AVADC_CH_EXTREG];
    end
  end

endmodule // avadc_top

// >>> inc/avadc_defines.vh
// Register map, field positions, reset values and timing for the aux ADC
`ifndef AVADC_DEFINES_VH
`define AVADC_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (7-bit SPI addresses)
// ----------------------------------------------------------------------
`define AVADC_ADDR_MODE 7'h01
`define AVADC_ADDR_TARGET 7'h07
`define AVADC_ADDR_CMD 7'h0c
`define AVADC_ADDR_PIN1 7'h0d
`define AVADC_ADDR_PULLUP 7'h11
`define AVADC_ADDR_STATUS 7'h1c
`define AVADC_ADDR_THERM_FIRST 7'h3f
`define AVADC_ADDR_THERM_LAST 7'h43
`define AVADC_ADDR_SUPPLY55 7'h44
`define AVADC_ADDR_CORE18 7'h49
`define AVADC_ADDR_EXTREG 7'h4a

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AVADC_BIT_CONT 15
`define AVADC_BIT_THERM_LO 1
`define AVADC_BIT_SUPPLY55 6
`define AVADC_BIT_CORE18 12
`define AVADC_BIT_EXTREG 13
`define AVADC_BIT_TRIG 4
`define AVADC_BIT_LATCH 0
`define AVADC_BIT_PIN1_NOE 1
`define AVADC_FLD_PIN1_SEL_HI 11
`define AVADC_FLD_PIN1_SEL_LO 8
`define AVADC_PIN1_SEL_IRQ 4'h3
`define AVADC_FLD_PULLUP_HI 7
`define AVADC_FLD_PULLUP_LO 3
`define AVADC_BIT_DONE 5

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define AVADC_RST_PIN1 16'h0002
`define AVADC_CODE_W 14
`define AVADC_NUM_CH 8
`define AVADC_CH_SUPPLY55 3'h5
`define AVADC_CH_CORE18 3'h6
`define AVADC_CH_EXTREG 3'h7

// ----------------------------------------------------------------------
// Timing: latch completes within the host wait time
// ----------------------------------------------------------------------
`define AVADC_CLK_MHZ 50
`define AVADC_LATCH_WAIT_NS 315
`define AVADC_LATCH_CYC ((`AVADC_LATCH_WAIT_NS * `AVADC_CLK_MHZ) / 1000)

`endif

// >>> testbench/avadc_core_model.sv
// Behavioural model of the analog converter core behind avadc_top
`timescale 1ns/1ps
module avadc_core_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Conversion request
  input wire adc_start_ff,
  input wire [2:0] adc_chan_ff,
  input wire [7:0] conv_cycles,
  // Conversion answer
  output reg adc_done,
  output reg [13:0] adc_code
);
  reg [7:0] cnt_ff; // Cycles left in conversion
  reg [2:0] chan_ff; // Channel under conversion
  // Answer each start after conv_cycles clocks
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      chan_ff <= 3'h0;
      adc_done <= 1'b0;
      adc_code <= 14'h0000;
    end else begin
      adc_done <= 1'b0;
      adc_code <= ~adc_code; // Code not valid outside done
      if (adc_start_ff) begin
        cnt_ff <= conv_cycles;
        chan_ff <= adc_chan_ff;
      end else if (cnt_ff == 8'h01) begin
        cnt_ff <= 8'h00;
        adc_done <= 1'b1;
        case (chan_ff)
          3'h5: adc_code <= 14'h3fff; // Full scale code
          3'h6: adc_code <= 14'h2000; // Mid scale code
          3'h7: adc_code <= 14'h0001; // One step code
          default: adc_code <= {11'h020, chan_ff}; // Thermistor code
        endcase
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule // avadc_core_model

// >>> testbench/avadc_monitor.sv
// Checker of the aux ADC control pins, bound to avadc_top
`timescale 1ns/1ps
module avadc_monitor (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // SPI pins
  input wire spi_cs_n,
  input wire spi_miso_oe,
  // Pin 1 and converter core
  input wire pin1_out_ff,
  input wire adc_start_ff,
  input wire [2:0] adc_chan_ff,
  input wire adc_done,
  input wire [4:0] pullup_en_ff
);
  reg busy_ff; // Conversion pending between start and done
  // Track the outstanding conversion
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (adc_start_ff) begin
      busy_ff <= 1'b1;
    end else if (adc_done) begin
      busy_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sel;
    !spi_cs_n [*5];
  endsequence
  sequence s_idle;
    spi_cs_n [*5];
  endsequence
  sequence s_quiet;
    (!busy_ff && !adc_start_ff) [*2];
  endsequence
  a_oe_when_sel: assert property (s_sel |=> spi_miso_oe)
    else $error("miso not enabled while selected");
  a_oe_when_idle: assert property (s_idle |=> !spi_miso_oe)
    else $error("miso enabled while idle");
  a_pullup_match: assert property (pullup_en_ff != 5'h00 |->
    pullup_en_ff == (5'h01 << adc_chan_ff) && adc_chan_ff < 3'h5)
    else $error("pull-up on for wrong input");
  a_pullup_idle: assert property (s_quiet |-> pullup_en_ff == 5'h00)
    else $error("pull-up on outside conversion");
  a_start_pulse: assert property (adc_start_ff |=> !adc_start_ff)
    else $error("start longer than one cycle");
  a_no_start_busy: assert property (busy_ff |-> !adc_start_ff)
    else $error("start while conversion pending");
  a_chan_held: assert property (busy_ff |-> $stable(adc_chan_ff))
    else $error("channel moved during conversion");
  a_irq_not_busy: assert property ($rose(pin1_out_ff) |->
    !busy_ff && !adc_start_ff)
    else $error("done interrupt during conversion");
  a_irq_held: assert property ($rose(pin1_out_ff) |=> pin1_out_ff [*8])
    else $error("done interrupt dropped early");
endmodule // avadc_monitor
bind avadc_top avadc_monitor u_avadc_monitor (
  .clk(clk),
  .rst_n(rst_n),
  .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe),
  .pin1_out_ff(pin1_out_ff),
  .adc_start_ff(adc_start_ff),
  .adc_chan_ff(adc_chan_ff),
  .adc_done(adc_done),
  .pullup_en_ff(pullup_en_ff)
);

// >>> testbench/avadc_top_tb.sv
// Self-checking bench of the aux ADC control block
`timescale 1ns/1ps
`include "avadc_defines.vh"
`define CHK(nm, ex, gt) begin checked = checked + 1; \
  if ((gt) !== (ex)) begin mismatches = mismatches + 1; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module avadc_top_tb;
  // Design pins
  reg clk;
  reg rst_n;
  reg spi_sck;
  reg spi_cs_n;
  reg spi_mosi;
  wire spi_miso;
  wire spi_miso_oe;
  wire pin1_out_ff;
  wire pin1_oe_ff;
  wire adc_start_ff;
  wire [2:0] adc_chan_ff;
  wire adc_done;
  wire [13:0] adc_code;
  wire [4:0] pullup_en_ff;
  // Bench state
  reg [7:0] conv_cycles; // Model conversion time
  reg [7:0] chan_seen; // Channels started
  reg [4:0] pull_seen; // Pull-ups seen on
  reg [15:0] q; // Read data
  integer mismatches;
  integer checked;
  integer cycles;
  integer starts;
  integer n;
  avadc_top u_avadc_top (.clk(clk), .rst_n(rst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .pin1_out_ff(pin1_out_ff),
    .pin1_oe_ff(pin1_oe_ff), .adc_start_ff(adc_start_ff),
    .adc_chan_ff(adc_chan_ff), .adc_done(adc_done), .adc_code(adc_code),
    .pullup_en_ff(pullup_en_ff));
  avadc_core_model u_avadc_core_model (.clk(clk), .rst_n(rst_n),
    .adc_start_ff(adc_start_ff), .adc_chan_ff(adc_chan_ff),
    .conv_cycles(conv_cycles), .adc_done(adc_done), .adc_code(adc_code));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Observer of starts and pull-ups, and hang limit
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (adc_start_ff === 1'b1) begin
      chan_seen = chan_seen | (8'h01 << adc_chan_ff);
      starts = starts + 1;
    end
    pull_seen = pull_seen | pullup_en_ff;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  // Step k clocks, then drive just after the edge
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  // One 24-bit SPI frame, mode 0, MSB first
  task xfer(input w, input [6:0] a, input [15:0] wd, output [15:0] rq);
    reg [23:0] sh;
    integer i;
    begin
      sh = {w, a, wd};
      rq = 16'h0000;
      spi_cs_n = 1'b0;
      for (i = 23; i >= 0; i = i - 1) begin
        spi_mosi = sh[i];
        tick(10);
        spi_sck = 1'b1;
        if (i < 16) rq[i] = spi_miso;
        tick(10);
        spi_sck = 1'b0;
      end
      tick(10);
      spi_cs_n = 1'b1;
      tick(10);
    end
  endtask
  task wr(input [6:0] a, input [15:0] d);
    reg [15:0] dq;
    begin
      xfer(1'b1, a, d, dq);
    end
  endtask
  task rd(input [6:0] a);
    begin
      xfer(1'b0, a, 16'h0000, q);
    end
  endtask
  // Reset state of pin 1, then route the done interrupt
  task t_pin1;
    begin
      rd(`AVADC_ADDR_PIN1);
      `CHK("pin1 cfg", `AVADC_RST_PIN1, q)
      `CHK("pin1 oe", 1'b0, pin1_oe_ff)
      wr(`AVADC_ADDR_PIN1, 16'h0300);
      `CHK("pin1 oe on", 1'b1, pin1_oe_ff)
      $display("test pin1 done");
    end
  endtask
  // One-shot over three rails
  task t_oneshot;
    begin
      wr(`AVADC_ADDR_TARGET, 16'h3040);
      chan_seen = 8'h00;
      starts = 0;
      wr(`AVADC_ADDR_CMD, 16'h0010);
      n = 0;
      while (pin1_out_ff !== 1'b1 && n < 2000) begin
        tick(1);
        n = n + 1;
      end
      `CHK("irq high", 1'b1, pin1_out_ff)
      `CHK("channels", 8'he0, chan_seen)
      rd(`AVADC_ADDR_STATUS);
      `CHK("done flag", 16'h0020, q)
      rd(`AVADC_ADDR_CMD);
      `CHK("trigger", 1'b0, q[4])
      rd(`AVADC_ADDR_SUPPLY55);
      `CHK("unlatched", 16'h0000, q)
      `CHK("one cycle", 3, starts)
      $display("test oneshot done");
    end
  endtask
  // Latch, results, read-only and unmapped places
  task t_latch;
    begin
      wr(`AVADC_ADDR_CMD, 16'h0001);
      tick(16); // Host waits beyond 315 ns
      `CHK("irq low", 1'b0, pin1_out_ff)
      rd(`AVADC_ADDR_CMD);
      `CHK("latch bit", 16'h0000, q)
      rd(`AVADC_ADDR_SUPPLY55);
      `CHK("supply55", 16'h3fff, q)
      rd(`AVADC_ADDR_CORE18);
      `CHK("core18", 16'h2000, q)
      rd(`AVADC_ADDR_EXTREG);
      `CHK("extreg", 16'h0001, q)
      wr(`AVADC_ADDR_SUPPLY55, 16'h1234);
      rd(`AVADC_ADDR_SUPPLY55);
      `CHK("result ro", 16'h3fff, q)
      rd(7'h60);
      `CHK("unmapped", 16'h0000, q)
      $display("test latch done");
    end
  endtask
  // Done flag clears only on a one in bit 5
  task t_clear;
    begin
      wr(`AVADC_ADDR_STATUS, 16'hffdf);
      rd(`AVADC_ADDR_STATUS);
      `CHK("flag kept", 16'h0020, q)
      wr(`AVADC_ADDR_STATUS, 16'h0020);
      rd(`AVADC_ADDR_STATUS);
      `CHK("flag clear", 16'h0000, q)
      $display("test clear done");
    end
  endtask
  // Continuous cycles on the 5.5V rail with a slow core
  task t_cont;
    begin
      conv_cycles = 8'h14;
      wr(`AVADC_ADDR_TARGET, 16'h0040);
      chan_seen = 8'h00;
      starts = 0;
      wr(`AVADC_ADDR_MODE, 16'h8000);
      tick(300);
      `CHK("repeats", 1'b1, starts > 5)
      `CHK("rail only", 8'h20, chan_seen)
      wr(`AVADC_ADDR_MODE, 16'h0000);
      tick(100);
      n = starts;
      tick(300);
      `CHK("stopped", n, starts)
      $display("test cont done");
    end
  endtask
  // Thermistor inputs, pull-up gating and codes
  task t_therm;
    begin
      conv_cycles = 8'h03;
      wr(`AVADC_ADDR_PULLUP, 16'h0028);
      wr(`AVADC_ADDR_TARGET, 16'h0006);
      chan_seen = 8'h00;
      pull_seen = 5'h00;
      wr(`AVADC_ADDR_CMD, 16'h0010);
      tick(200);
      `CHK("therm chans", 8'h03, chan_seen)
      `CHK("pull-ups", 5'h01, pull_seen)
      wr(`AVADC_ADDR_CMD, 16'h0001);
      tick(16);
      rd(`AVADC_ADDR_THERM_FIRST);
      `CHK("therm1", 16'h0100, q)
      rd(7'h40);
      `CHK("therm2", 16'h0101, q)
      $display("test therm done");
    end
  endtask
  // Verdict and end of run
  task end_of_test;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    conv_cycles = 8'h03;
    chan_seen = 8'h00;
    pull_seen = 5'h00;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    starts = 0;
    tick(20);
    rst_n = 1'b1;
    tick(2);
    t_pin1;
    t_oneshot;
    t_latch;
    t_clear;
    t_cont;
    t_therm;
    end_of_test;
  end
endmodule // avadc_top_tb
